/* hw/pad_aux_pd.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Serial bits shift under strobe, captured on fall.
// - Each function bit acts only when one.
// - Bit 3 powers down all but loading.
// - Bit 4 forces continuous counter load.
// - Bit 5 routes modulus select to diagnostic.
// - Bit 6 routes prescaler output to diagnostic when bit 5 is zero.
// - Bit 7 disables both divided phase outputs.
// - Detector acts only on rising edges.
// - VCO edge first pulses down output low.
// - Reference edge first pulses up output low.
// - Pulse width tracks the edge offset.
// - Lock is inverted filtered NAND of pumps.
// - Parallel data latched on strobe rising edge.
// - Register acts only while enable is low.
// - First serial bit is bit 0, lines reversed.
module pad_aux_pd
(
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  input  wire logic             serial_clk,
  input  wire logic             serial_data,
  input  wire logic             aux_wr,
  input  wire logic [7:0]       par_data,
  input  wire logic             smode,
  input  wire logic             bmode,
  input  wire logic             aux_en_n,
  input  wire logic             vco_div_in,
  input  wire logic             ref_div_in,
  input  wire logic             modulus_select,
  input  wire logic             prescaler_raw,
  output logic                  pump_up_n,
  output logic                  pump_down_n,
  output logic                  lock_indicator,
  output logic                  divided_vco_phase,
  output logic                  divided_reference_phase,
  output logic                  diag_out,
  output logic                  force_counter_load,
  output pad_pkg::pad_src_t     load_source,
  output logic                  power_down
);
  import pad_pkg::*;

  logic [PIN_W-1:0]  pin_raw;
  logic [PIN_W-1:0]  sync1_q;
  logic [PIN_W-1:0]  sync1_d;
  logic [PIN_W-1:0]  sync2_q;
  logic [PIN_W-1:0]  sync2_d;
  logic [PIN_W-1:0]  prev_q;
  logic [PIN_W-1:0]  prev_d;
  logic [7:0]        par1_q;
  logic [7:0]        par1_d;
  logic [7:0]        par2_q;
  logic [7:0]        par2_d;
  logic [7:0]        par_rev;

  assign pin_raw = {prescaler_raw, modulus_select, ref_div_in, vco_div_in, aux_en_n,
                    bmode, smode, aux_wr, serial_data, serial_clk};

  // Every pin passes two flops; edges are found against a third copy of the second stage.
  always_comb
  begin
    sync1_d = clk_en ? pin_raw : sync1_q;
    sync2_d = clk_en ? sync1_q : sync2_q;
    prev_d  = clk_en ? sync2_q : prev_q;
    par1_d  = clk_en ? par_data : par1_q;
    par2_d  = clk_en ? par1_q : par2_q;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q <= PIN_RESET;
      sync2_q <= PIN_RESET;
      prev_q  <= PIN_RESET;
      par1_q  <= 8'h00;
      par2_q  <= 8'h00;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
      par1_q  <= par1_d;
      par2_q  <= par2_d;
    end
  end

  logic sclk_rise;
  logic wr_rise;
  logic wr_fall;
  logic vco_rise;
  logic ref_rise;
  logic serial_mode;
  logic en_active;

  assign sclk_rise   = sync2_q[PIN_SCLK] & ~prev_q[PIN_SCLK];
  assign wr_rise     = sync2_q[PIN_WR] & ~prev_q[PIN_WR];
  assign wr_fall     = ~sync2_q[PIN_WR] & prev_q[PIN_WR];
  assign vco_rise    = sync2_q[PIN_VCO] & ~prev_q[PIN_VCO];
  assign ref_rise    = sync2_q[PIN_REF] & ~prev_q[PIN_REF];
  assign serial_mode = sync2_q[PIN_SMODE];
  assign en_active   = ~sync2_q[PIN_EN_N];

  genvar gi;
  generate
    for (gi = 0; gi < AUX_W; gi++)
    begin : g_rev
      assign par_rev[gi] = par2_q[AUX_W-1-gi];
    end
  endgenerate

  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] aux_q;
  logic [7:0] aux_d;

  // The shifter is separate from the live register so a half-loaded word never steers anything.
  always_comb
  begin
    shift_d = shift_q;
    aux_d   = aux_q;
    if (clk_en)
    begin
      if (serial_mode && sync2_q[PIN_WR] && sclk_rise)
      begin
        shift_d = {sync2_q[PIN_SDATA], shift_q[7:1]};
      end
      if (serial_mode && wr_fall)
      begin
        aux_d = shift_q;
      end
      else if (!serial_mode && wr_rise)
      begin
        aux_d = par_rev;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_q <= AUX_RESET;
      aux_q   <= AUX_RESET;
    end
    else
    begin
      shift_q <= shift_d;
      aux_q   <= aux_d;
    end
  end

  logic [7:0] eff;
  logic       pd_on;

  // Reserved bits are stored but steer nothing.
  assign eff   = en_active ? aux_q : 8'h00;
  assign pd_on = eff[BIT_PWR_DOWN];

  logic up_q;
  logic up_d;
  logic dn_q;
  logic dn_d;

  // Pulse width is quantised to the clock period, so offsets below 4 ns are lost.
  always_comb
  begin
    up_d = up_q;
    dn_d = dn_q;
    if (clk_en)
    begin
      if (pd_on)
      begin
        up_d = 1'b0;
        dn_d = 1'b0;
      end
      else
      begin
        up_d = up_q | ref_rise;
        dn_d = dn_q | vco_rise;
        if (up_d && dn_d)
        begin
          up_d = 1'b0;
          dn_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end
    else
    begin
      up_q <= up_d;
      dn_q <= dn_d;
    end
  end

  assign pump_up_n   = ~up_q;
  assign pump_down_n = ~dn_q;

  logic [FILT_W-1:0] filt_q;
  logic [FILT_W-1:0] filt_d;
  logic              nand_pumps;
  logic              lock_q;
  logic              lock_d;

  // The counter stands in for the external RC: lock drops once pump activity dominates.
  assign nand_pumps = ~(pump_up_n & pump_down_n);

  always_comb
  begin
    filt_d = filt_q;
    lock_d = lock_q;
    if (clk_en)
    begin
      if (nand_pumps && filt_q != FILT_MAX)
      begin
        filt_d = filt_q + 6'h01;
      end
      else if (!nand_pumps && filt_q != 6'h00)
      begin
        filt_d = filt_q - 6'h01;
      end
      lock_d = ~(filt_q >= FILT_THRESH) & ~pd_on;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      filt_q <= 6'h00;
      lock_q <= 1'b0;
    end
    else
    begin
      filt_q <= filt_d;
      lock_q <= lock_d;
    end
  end

  assign lock_indicator = lock_q;

  logic     vco_o_q;
  logic     vco_o_d;
  logic     ref_o_q;
  logic     ref_o_d;
  logic     diag_q;
  logic     diag_d;
  logic     load_q;
  logic     load_d;
  logic     pwr_q;
  logic     pwr_d;
  pad_src_t src_q;
  pad_src_t src_d;

  always_comb
  begin
    vco_o_d = vco_o_q;
    ref_o_d = ref_o_q;
    diag_d  = diag_q;
    load_d  = load_q;
    pwr_d   = pwr_q;
    src_d   = src_q;
    if (clk_en)
    begin
      vco_o_d = sync2_q[PIN_VCO] & ~eff[BIT_PHASE_OFF] & ~pd_on;
      ref_o_d = sync2_q[PIN_REF] & ~eff[BIT_PHASE_OFF] & ~pd_on;
      if (pd_on)
      begin
        diag_d = 1'b0;
      end
      else if (eff[BIT_MODSEL_OUT])
      begin
        diag_d = sync2_q[PIN_MODSEL];
      end
      else if (eff[BIT_PSC_OUT])
      begin
        diag_d = sync2_q[PIN_PSC];
      end
      else
      begin
        diag_d = 1'b0;
      end
      load_d = eff[BIT_CNT_LOAD] & ~pd_on;
      pwr_d  = pd_on;
      if (sync2_q[PIN_BMODE])
      begin
        src_d = SRC_DIRECT;
      end
      else if (serial_mode)
      begin
        src_d = SRC_SERIAL;
      end
      else
      begin
        src_d = SRC_PARALLEL;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vco_o_q <= 1'b0;
      ref_o_q <= 1'b0;
      diag_q  <= 1'b0;
      load_q  <= 1'b0;
      pwr_q   <= 1'b0;
      src_q   <= SRC_PARALLEL;
    end
    else
    begin
      vco_o_q <= vco_o_d;
      ref_o_q <= ref_o_d;
      diag_q  <= diag_d;
      load_q  <= load_d;
      pwr_q   <= pwr_d;
      src_q   <= src_d;
    end
  end

  assign divided_vco_phase       = vco_o_q;
  assign divided_reference_phase = ref_o_q;
  assign diag_out                = diag_q;
  assign force_counter_load      = load_q;
  assign load_source             = src_q;
  assign power_down              = pwr_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b || !clk_en);

  sequence s_ser_word_end;
    serial_mode && wr_fall;
  endsequence

  a_ser_capture: assert property (s_ser_word_end |=> aux_q == $past(shift_q))
    else $error("serial word not captured on strobe fall");

  a_ser_shift_in: assert property (serial_mode && sync2_q[PIN_WR] && sclk_rise
    |=> shift_q[7] == $past(sync2_q[PIN_SDATA]))
    else $error("serial bit not shifted into the top");

  a_par_latch: assert property (!serial_mode && wr_rise |=> aux_q == $past(par_rev))
    else $error("parallel word not latched on strobe rise");

  a_enh_gate: assert property (!en_active |=> !power_down && !force_counter_load
    && !diag_out)
    else $error("register acts while enable is high");

  a_pwr_quiet: assert property (pd_on [*2] |=> pump_up_n && pump_down_n
    && !divided_vco_phase && !divided_reference_phase && !diag_out && power_down
    && !lock_indicator && !force_counter_load)
    else $error("outputs active during power down");

  a_phase_off: assert property (eff[BIT_PHASE_OFF] |=> !divided_vco_phase
    && !divided_reference_phase)
    else $error("phase outputs not disabled");

  a_diag_modsel: assert property (!pd_on && eff[BIT_MODSEL_OUT]
    |=> diag_out == $past(sync2_q[PIN_MODSEL]))
    else $error("modulus select not routed");

  a_load_force: assert property (!pd_on && eff[BIT_CNT_LOAD] |=> force_counter_load)
    else $error("counter load not forced");

  a_down_pulse: assert property (!pd_on && vco_rise && !ref_rise && !up_q
    |=> !pump_down_n && pump_up_n)
    else $error("down pulse missing after vco edge");

  a_up_pulse: assert property (!pd_on && ref_rise && !vco_rise && !dn_q
    |=> !pump_up_n && pump_down_n)
    else $error("up pulse missing after reference edge");

  a_pump_excl: assert property (!(!pump_up_n && !pump_down_n))
    else $error("both pump outputs low together");

  a_lock_filter: assert property (filt_q == FILT_MAX |=> !lock_indicator)
    else $error("lock held despite pump activity");

endmodule : pad_aux_pd
`default_nettype wire

/* hw/pad_pkg.sv */
`default_nettype none
package pad_pkg;

  localparam int            AUX_W            = 8;
  localparam logic [7:0]    AUX_RESET        = 8'h00;

  localparam int            RSV_TOP          = 2;
  localparam int            BIT_PWR_DOWN     = 3;
  localparam int            BIT_CNT_LOAD     = 4;
  localparam int            BIT_MODSEL_OUT   = 5;
  localparam int            BIT_PSC_OUT      = 6;
  localparam int            BIT_PHASE_OFF    = 7;

  localparam int            PIN_W            = 10;
  localparam int            PIN_SCLK         = 0;
  localparam int            PIN_SDATA        = 1;
  localparam int            PIN_WR           = 2;
  localparam int            PIN_SMODE        = 3;
  localparam int            PIN_BMODE        = 4;
  localparam int            PIN_EN_N         = 5;
  localparam int            PIN_VCO          = 6;
  localparam int            PIN_REF          = 7;
  localparam int            PIN_MODSEL       = 8;
  localparam int            PIN_PSC          = 9;
  localparam logic [9:0]    PIN_RESET        = 10'h020;

  localparam int            FILT_W           = 6;
  localparam logic [5:0]    FILT_MAX         = 6'h3f;
  localparam logic [5:0]    FILT_THRESH      = 6'h20;

  typedef enum logic [1:0] {
    SRC_PARALLEL,
    SRC_SERIAL,
    SRC_DIRECT
  } pad_src_t;

endpackage : pad_pkg
`default_nettype wire

/* verif/pad_aux_pd_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pad_aux_pd_bench;
  import pad_pkg::*;
  logic        clock    = 1'b0;
  logic        rst_b    = 1'b0;
  logic        smode    = 1'b1;
  logic        bmode    = 1'b0;
  logic        aux_en_n = 1'b0;
  logic        vco      = 1'b1;
  logic        refc     = 1'b1;
  logic        modsel   = 1'b0;
  logic        clk_en   = 1'b1;
  logic        psc      = 1'b0;
  logic        sclk, sdata, wr, up_n, dn_n, lock, vph, rph, diag, fcl, pwd;
  logic [7:0]  pdata;
  pad_src_t    lsrc;
  logic [31:0] seed     = 32'h759ad39b;
  int          model    = 0;
  int          err_total  = 0;
  int          num_checks = 0;
  int          offs[$]  = '{0, 3, 17, 50};

  always #2 clock = ~clock;

  pad_host_model host_u (.clock(clock), .serial_clk(sclk), .serial_data(sdata),
    .aux_wr(wr), .par_data(pdata));

  pad_aux_pd dut_u (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .serial_clk(sclk),
    .serial_data(sdata), .aux_wr(wr), .par_data(pdata), .smode(smode), .bmode(bmode),
    .aux_en_n(aux_en_n), .vco_div_in(vco), .ref_div_in(refc), .modulus_select(modsel),
    .prescaler_raw(psc), .pump_up_n(up_n), .pump_down_n(dn_n), .lock_indicator(lock),
    .divided_vco_phase(vph), .divided_reference_phase(rph), .diag_out(diag),
    .force_counter_load(fcl), .load_source(lsrc), .power_down(pwd));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic load(input logic [7:0] v);
    seed = xs(seed);
    {modsel, psc, bmode} = seed[2:0];
    model = int'(v & 8'hf8);
    if (smode)
      host_u.load_serial(v & 8'hf8);
    else
      host_u.load_par(v & 8'hf8);
  endtask : load

  // Outputs are registered behind synchronisers, so allow eight clocks to settle.
  task automatic check_outs;
    int a;
    int pd;
    a  = aux_en_n ? 0 : model;
    pd = (a >> 3) & 1;
    repeat (8) @(negedge clock);
    chk(8'(pwd), 8'(pd));
    chk(8'(fcl), 8'(((a >> 4) & 1) & ~pd));
    chk(8'(diag), 8'((pd == 0) && (a[5] ? modsel : (a[6] ? psc : 1'b0))));
    chk(8'({vph, rph}), (a[7] | pd) ? 8'h00 : 8'h03);
    chk(8'(lsrc), bmode ? 8'h02 : 8'(smode));
  endtask : check_outs

  task automatic pulse(input int k, input logic vfirst, input logic live);
    int up;
    int dn;
    logic dropped;
    up = 0;
    dn = 0;
    dropped = 1'b0;
    {vco, refc} = 2'b00;
    repeat (8) @(negedge clock);
    if (k == 0)
      {vco, refc} = 2'b11;
    else if (vfirst)
      vco = 1'b1;
    else
      refc = 1'b1;
    for (int i = 0; i < 70; i++)
    begin
      if (i == k && k > 0)
        {vco, refc} = 2'b11;
      @(negedge clock);
      up += (up_n === 1'b0);
      dn += (dn_n === 1'b0);
      dropped |= (lock !== 1'b1);
    end
    chk(8'(dn), (live && vfirst) ? 8'(k) : 8'h00);
    chk(8'(up), (live && !vfirst) ? 8'(k) : 8'h00);
    chk(8'(dropped), live ? 8'(k >= int'(FILT_THRESH)) : 8'h01);
  endtask : pulse

  initial
  begin
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      aux_en_n = seed[9];
      load(seed[31:24]);
      check_outs();
    end
    $display("test serial done");
    smode = 1'b0;
    for (int b = 3; b < 9; b++)
    begin
      aux_en_n = (b == 8);
      load(8'h01 << b[2:0]);
      check_outs();
    end
    aux_en_n = 1'b0;
    $display("test parallel done");
    load(8'h00);
    foreach (offs[i])
    begin
      pulse(offs[i], 1'b1, 1'b1);
      pulse(offs[i], 1'b0, 1'b1);
    end
    $display("test detector done");
    // A low enable must freeze the synchronisers, so the phase outputs keep their level.
    clk_en = 1'b0;
    {vco, refc} = 2'b00;
    repeat (8) @(negedge clock);
    chk(8'({vph, rph}), 8'h03);
    clk_en = 1'b1;
    repeat (8) @(negedge clock);
    chk(8'({vph, rph}), 8'h00);
    $display("test clock enable done");
    load(8'h08);
    pulse(10, 1'b1, 1'b0);
    pulse(10, 1'b0, 1'b0);
    $display("test power down done");
    give_verdict();
  end
endmodule : pad_aux_pd_bench
`default_nettype wire

/* verif/pad_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pad_host_model
(
  input  wire logic       clock,
  output var  logic       serial_clk,
  output var  logic       serial_data,
  output var  logic       aux_wr,
  output var  logic [7:0] par_data
);
  initial
  begin
    serial_clk  = 1'b0;
    serial_data = 1'b0;
    aux_wr      = 1'b0;
    par_data    = 8'h00;
  end

  // Each shift clock phase lasts 40 ns, ten system clocks.
  task automatic load_serial(input logic [7:0] v);
    aux_wr = 1'b1;
    repeat (3) @(negedge clock);
    for (int i = 0; i < 8; i++)
    begin
      serial_data = v[i];
      repeat (10) @(negedge clock);
      serial_clk = 1'b1;
      repeat (10) @(negedge clock);
      serial_clk = 1'b0;
    end
    repeat (3) @(negedge clock);
    aux_wr = 1'b0;
    // The data line is not held after the frame, so show a changed level.
    serial_data = ~serial_data;
  endtask : load_serial

  task automatic load_par(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
    begin
      par_data[7-i] = v[i];
    end
    repeat (3) @(negedge clock);
    aux_wr = 1'b1;
    repeat (6) @(negedge clock);
    aux_wr = 1'b0;
    repeat (3) @(negedge clock);
    par_data = ~par_data;
  endtask : load_par
endmodule : pad_host_model
`default_nettype wire
